// *** src/bst_tap.sv ***
`timescale 1ns/100ps
`default_nettype none

module bst_tap (
    // System
    input  wire logic                          sys_clk,
    input  wire logic                          rst_b,
    // Test access port
    input  wire logic                          tck,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    output logic                               tdo,
    output logic                               tdo_oe,
    // Device pins
    input  wire logic [bst_pkg::NUM_PINS-1:0]  pin_in,
    output logic      [bst_pkg::NUM_PINS-1:0]  pin_out,
    // Core side
    input  wire logic [bst_pkg::NUM_PINS-1:0]  core_out,
    output logic      [bst_pkg::NUM_PINS-1:0]  core_in
);

    logic [1:0]                  rst_sync_reg;
    logic                        rst_int_b;
    logic [1:0]                  tck_sync_reg;
    logic [1:0]                  tms_sync_reg;
    logic [1:0]                  tdi_sync_reg;
    logic [bst_pkg::NUM_PINS-1:0] pin_s1_reg;
    logic [bst_pkg::NUM_PINS-1:0] pin_s2_reg;
    logic                        tck_prev_reg;
    logic                        tck_rise;
    logic                        tck_fall;
    bst_pkg::bst_state_t         state;
    logic [bst_pkg::IR_LEN-1:0]  ir_shift_reg;
    logic [bst_pkg::IR_LEN-1:0]  ir_reg;
    logic                        bypass_reg;
    logic [bst_pkg::ID_LEN-1:0]  id_reg;
    logic [bst_pkg::BSR_LEN-1:0] bsr_reg;
    logic [bst_pkg::BSR_LEN-1:0] bsr_upd_reg;
    logic                        dr_bit;
    logic                        extest;

    // Boundary register is the scan path for both of these codes
    function automatic logic bsr_code(
        input logic [bst_pkg::IR_LEN-1:0] code
    );
        return (code == bst_pkg::INS_EXTEST)
               || (code == bst_pkg::INS_SAMPLE);
    endfunction

    // Either shift state puts the driver on the data out pin
    function automatic logic shifting(input bst_pkg::bst_state_t s);
        return (s == bst_pkg::SHIFT_IR) || (s == bst_pkg::SHIFT_DR);
    endfunction

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'h1};
        end
    end
    assign rst_int_b = rst_sync_reg[1];

    // Pins cross in through two flops; test clock is sampled, not used as one
    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            tck_sync_reg <= 2'h0;
            tms_sync_reg <= 2'h3;
            tdi_sync_reg <= 2'h3;
            pin_s1_reg   <= '0;
            pin_s2_reg   <= '0;
            tck_prev_reg <= 1'h0;
        end else begin
            tck_sync_reg <= {tck_sync_reg[0], tck};
            tms_sync_reg <= {tms_sync_reg[0], tms};
            tdi_sync_reg <= {tdi_sync_reg[0], tdi};
            pin_s1_reg   <= pin_in;
            pin_s2_reg   <= pin_s1_reg;
            tck_prev_reg <= tck_sync_reg[1];
        end
    end

    // Edges last one cycle; test clock phases shorter than one cycle can be lost
    assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
    assign tck_fall = ~tck_sync_reg[1] & tck_prev_reg;

    bst_fsm u_fsm (
        .clk      (sys_clk),
        .rst_b    (rst_int_b),
        .tck_rise (tck_rise),
        .tms      (tms_sync_reg[1]),
        .state    (state)
    );

    // Instruction register: capture, shift, update
    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            ir_shift_reg <= bst_pkg::IR_RESET;
            ir_reg       <= bst_pkg::IR_RESET;
        end else if (state == bst_pkg::TEST_LOGIC_RESET) begin
            ir_shift_reg <= bst_pkg::IR_RESET;
            ir_reg       <= bst_pkg::IR_RESET;
        end else if (tck_rise && state == bst_pkg::CAPTURE_IR) begin
            ir_shift_reg <= bst_pkg::IR_CAPTURE;
        end else if (tck_rise && state == bst_pkg::SHIFT_IR) begin
            ir_shift_reg <= {tdi_sync_reg[1],
                             ir_shift_reg[bst_pkg::IR_LEN-1:1]};
        end else if (tck_fall && state == bst_pkg::UPDATE_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    assign extest = (ir_reg == bst_pkg::INS_EXTEST);

    // Bypass register
    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            bypass_reg <= 1'h0;
        end else if (tck_rise && state == bst_pkg::CAPTURE_DR) begin
            bypass_reg <= 1'h0;
        end else if (tck_rise && state == bst_pkg::SHIFT_DR) begin
            bypass_reg <= tdi_sync_reg[1];
        end
    end

    // Identification register
    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            id_reg <= bst_pkg::ID_VALUE;
        end else if (tck_rise && state == bst_pkg::CAPTURE_DR) begin
            id_reg <= bst_pkg::ID_VALUE;
        end else if (tck_rise && state == bst_pkg::SHIFT_DR
                     && ir_reg == bst_pkg::INS_IDCODE) begin
            id_reg <= {tdi_sync_reg[1], id_reg[bst_pkg::ID_LEN-1:1]};
        end
    end

    // Boundary cells: low half watches inputs, high half the outputs
    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            bsr_reg     <= bst_pkg::BSR_RESET;
            bsr_upd_reg <= bst_pkg::BSR_RESET;
        end else if (state == bst_pkg::TEST_LOGIC_RESET) begin
            bsr_upd_reg <= bst_pkg::BSR_RESET;
        end else if (bsr_code(ir_reg)) begin
            if (tck_rise && state == bst_pkg::CAPTURE_DR) begin
                bsr_reg <= {pin_out, pin_s2_reg};
            end else if (tck_rise && state == bst_pkg::SHIFT_DR) begin
                bsr_reg <= {tdi_sync_reg[1],
                            bsr_reg[bst_pkg::BSR_LEN-1:1]};
            end else if (tck_fall && state == bst_pkg::UPDATE_DR) begin
                bsr_upd_reg <= bsr_reg;
            end
        end
    end

    // Output cells take over the pins only under EXTEST
    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            pin_out <= '0;
            core_in <= '0;
        end else begin
            pin_out <= extest
                ? bsr_upd_reg[bst_pkg::BSR_LEN-1:bst_pkg::NUM_PINS]
                : core_out;
            core_in <= pin_s2_reg;
        end
    end

    // Unknown codes fall back to bypass
    always_comb begin
        if (bsr_code(ir_reg)) begin
            dr_bit = bsr_reg[0];
        end else if (ir_reg == bst_pkg::INS_IDCODE) begin
            dr_bit = id_reg[0];
        end else begin
            dr_bit = bypass_reg;
        end
    end

    // Driver enable follows the shift states, updated on the falling clock
    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            tdo_oe <= 1'h0;
        end else if (tck_fall) begin
            tdo_oe <= shifting(state);
        end
    end

    // Data out moves on the falling clock so the tester samples it settled
    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            tdo <= 1'h0;
        end else if (tck_fall) begin
            tdo <= (state == bst_pkg::SHIFT_IR) ? ir_shift_reg[0]
                                                : dr_bit;
        end
    end

endmodule

`default_nettype wire

// *** src/bst_pkg.sv ***
`default_nettype none

package bst_pkg;

    // Controller states, sixteen in all, held in four bits
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } bst_state_t;

    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int NUM_PINS = 4;
    localparam int BSR_LEN = 2 * NUM_PINS;

    // Instruction codes
    localparam logic [IR_LEN-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_LEN-1:0] INS_SAMPLE = 3'h1;
    localparam logic [IR_LEN-1:0] INS_IDCODE = 3'h2;
    localparam logic [IR_LEN-1:0] INS_BYPASS = 3'h7;

    // Fixed pattern loaded into the instruction register on capture
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;
    localparam logic [IR_LEN-1:0] IR_RESET = INS_IDCODE;

    // Identification fields; values are arbitrary
    localparam logic [3:0]  ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART    = 16'h0042;
    localparam logic [10:0] ID_MAKER   = 11'h0AB;
    localparam logic        ID_LSB     = 1'h1;
    localparam logic [ID_LEN-1:0] ID_VALUE =
        {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};

    localparam logic [BSR_LEN-1:0] BSR_RESET = 8'h00;

endpackage

`default_nettype wire

// *** src/bst_fsm.sv ***
`timescale 1ns/100ps
`default_nettype none

module bst_fsm (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Sampled link
    input  wire logic             tck_rise,
    input  wire logic             tms,
    // State
    output bst_pkg::bst_state_t   state
);

    bst_pkg::bst_state_t state_next;

    always_comb begin
        state_next = state;
        case (state)
            bst_pkg::TEST_LOGIC_RESET:
                state_next = tms ? bst_pkg::TEST_LOGIC_RESET
                                 : bst_pkg::RUN_TEST_IDLE;
            bst_pkg::RUN_TEST_IDLE:
                state_next = tms ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
            bst_pkg::SELECT_DR:
                state_next = tms ? bst_pkg::SELECT_IR : bst_pkg::CAPTURE_DR;
            bst_pkg::CAPTURE_DR:
                state_next = tms ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
            bst_pkg::SHIFT_DR:
                state_next = tms ? bst_pkg::EXIT1_DR : bst_pkg::SHIFT_DR;
            bst_pkg::EXIT1_DR:
                state_next = tms ? bst_pkg::UPDATE_DR : bst_pkg::PAUSE_DR;
            bst_pkg::PAUSE_DR:
                state_next = tms ? bst_pkg::EXIT2_DR : bst_pkg::PAUSE_DR;
            bst_pkg::EXIT2_DR:
                state_next = tms ? bst_pkg::UPDATE_DR : bst_pkg::SHIFT_DR;
            bst_pkg::UPDATE_DR:
                state_next = tms ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
            bst_pkg::SELECT_IR:
                state_next = tms ? bst_pkg::TEST_LOGIC_RESET
                                 : bst_pkg::CAPTURE_IR;
            bst_pkg::CAPTURE_IR:
                state_next = tms ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
            bst_pkg::SHIFT_IR:
                state_next = tms ? bst_pkg::EXIT1_IR : bst_pkg::SHIFT_IR;
            bst_pkg::EXIT1_IR:
                state_next = tms ? bst_pkg::UPDATE_IR : bst_pkg::PAUSE_IR;
            bst_pkg::PAUSE_IR:
                state_next = tms ? bst_pkg::EXIT2_IR : bst_pkg::PAUSE_IR;
            bst_pkg::EXIT2_IR:
                state_next = tms ? bst_pkg::UPDATE_IR : bst_pkg::SHIFT_IR;
            bst_pkg::UPDATE_IR:
                state_next = tms ? bst_pkg::SELECT_DR : bst_pkg::RUN_TEST_IDLE;
            default:
                state_next = bst_pkg::TEST_LOGIC_RESET;
        endcase
    end

    // Moves only on a link clock rising edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= bst_pkg::TEST_LOGIC_RESET;
        end else if (tck_rise) begin
            state <= state_next;
        end
    end

endmodule

`default_nettype wire

// *** sim/bst_tap_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module bst_tap_checker (
    // System
    input wire logic                         sys_clk,
    input wire logic                         rst_b,
    // Test access port
    input wire logic                         tck,
    input wire logic                         tms,
    input wire logic                         tdo,
    input wire logic                         tdo_oe,
    // Pins and core
    input wire logic [bst_pkg::NUM_PINS-1:0] pin_in,
    input wire logic [bst_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [bst_pkg::NUM_PINS-1:0] core_out,
    input wire logic [bst_pkg::NUM_PINS-1:0] core_in
);
    logic       tck_reg;
    logic       last_tms_reg;
    logic       no_rise_reg;
    logic [2:0] ones_reg;
    logic [2:0] age_reg;
    wire logic  rise = tck && !tck_reg;
    wire logic  fall = !tck && tck_reg;

    // Own edge finder; runs ahead of the design's synchroniser
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tck_reg      <= 1'b0;
            last_tms_reg <= 1'b0;
            no_rise_reg  <= 1'b1;
            ones_reg     <= 3'h0;
            age_reg      <= 3'h0;
        end else begin
            tck_reg <= tck;
            age_reg <= age_reg + {2'h0, age_reg != 3'h7};
            if (rise) begin
                last_tms_reg <= tms;
                no_rise_reg  <= 1'b0;
                ones_reg     <= tms ? ones_reg + {2'h0, ones_reg != 3'h7}
                                    : 3'h0;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_b |-> !tdo_oe && !tdo && pin_out == '0 && core_in == '0)
        else $error("outputs active during reset");
    a_tdo_on_fall: assert property (
        $changed(tdo) |-> !$past(tck, 2) && !$past(tck, 3))
        else $error("tdo moved outside a tck low phase");
    a_oe_on_fall: assert property (
        $changed(tdo_oe) |-> !$past(tck, 2) && !$past(tck, 3))
        else $error("tdo_oe moved outside a tck low phase");
    a_core_in_follows: assert property (
        $stable(pin_in)[*8] |-> core_in == pin_in)
        else $error("core_in does not follow pin_in");
    a_five_high: assert property (
        ones_reg >= 3'h5 |-> !tdo_oe)
        else $error("shift still active after five high tms");
    a_exit_drops_oe: assert property (
        fall && last_tms_reg |-> ##5 !tdo_oe)
        else $error("tdo_oe kept after a high tms step");
    a_oe_needs_low: assert property (
        $rose(tdo_oe) |-> !last_tms_reg)
        else $error("shift entered on a high tms step");
    a_pins_follow: assert property (
        (age_reg >= 3'h4 && no_rise_reg) || ones_reg >= 3'h6
        |-> pin_out == $past(core_out))
        else $error("pin_out does not follow core_out");

    c_shift: cover property ($rose(tdo_oe));
    c_five: cover property (ones_reg == 3'h5);
    c_extest: cover property (pin_out != core_out);
endmodule
bind bst_tap bst_tap_checker u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out),
    .core_out(core_out), .core_in(core_in)
);
`default_nettype wire

// *** sim/bst_tester.sv ***
`timescale 1ns/100ps
`default_nettype none
module bst_tester (
    // System
    input  wire logic sys_clk,
    // Four-pin test port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 160 ns tck period; clock parks low between calls
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (8) @(negedge sys_clk);
        q = tdo;
        tck = 1'b1;
        repeat (8) @(negedge sys_clk);
        tck = 1'b0;
    endtask

    task automatic tlr();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
    endtask
endmodule
`default_nettype wire

// *** sim/bst_tap_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module bst_tap_bench;
    logic       sys_clk, rst_b, tck, tms, tdi, tdo, tdo_oe;
    logic [3:0] pin_in, pin_out, core_out, core_in;
    int         n_errors, samples_checked;

    bst_tap dut (.sys_clk(sys_clk), .rst_b(rst_b), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
        .pin_out(pin_out), .core_out(core_out), .core_in(core_in));
    bst_tester u_tst (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo));

    always #5 sys_clk = ~sys_clk;

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge sys_clk);
    endtask

    // From Run-Test/Idle through one scan and back; LSB first
    task automatic shift(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic q;
        dout = '0;
        u_tst.step(1'b1, 1'b0, q);
        if (ir) begin
            u_tst.step(1'b1, 1'b0, q);
        end
        u_tst.step(1'b0, 1'b0, q);
        u_tst.step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            u_tst.step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        u_tst.step(1'b1, 1'b0, q);
        u_tst.step(1'b0, 1'b0, q);
    endtask

    task automatic t_idcode();
        logic        q;
        logic [31:0] d;
        compare(32'(tdo_oe), 32'h0);
        u_tst.step(1'b0, 1'b0, q);
        shift(1'b0, 32, 32'h0, d);
        compare(d, bst_pkg::ID_VALUE);
    endtask

    // Unknown codes must fall back to the one-bit path
    task automatic t_bypass();
        logic [31:0] d;
        for (int c = 3; c < 8; c++) begin
            shift(1'b1, 3, 32'(c), d);
            compare(d, 32'(bst_pkg::IR_CAPTURE));
            shift(1'b0, 8, 32'hB5, d);
            compare(d, 32'h6A);
        end
    endtask

    task automatic t_boundary();
        logic [31:0] d;
        @(negedge sys_clk);
        pin_in = 4'hA;
        core_out = 4'h5;
        shift(1'b1, 3, 32'(bst_pkg::INS_SAMPLE), d);
        shift(1'b0, 8, 32'h3C, d);
        compare(d, 32'h5A);
        compare(32'(core_in), 32'hA);
        shift(1'b1, 3, 32'(bst_pkg::INS_EXTEST), d);
        compare(32'(pin_out), 32'h3);
        shift(1'b0, 8, 32'hC0, d);
        compare(d, 32'h3A);
        compare(32'(pin_out), 32'hC);
    endtask

    // Abort in mid Shift-IR, then five high steps
    task automatic t_tms_reset();
        logic        q;
        logic [31:0] d;
        for (int i = 0; i < 5; i++) begin
            u_tst.step(i < 2, 1'b1, q);
        end
        u_tst.tlr();
        u_tst.step(1'b0, 1'b0, q);
        compare(32'(pin_out), 32'h5);
        shift(1'b0, 32, 32'h0, d);
        compare(d, bst_pkg::ID_VALUE);
    endtask

    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        pin_in = 4'h0;
        core_out = 4'h0;
        n_errors = 0;
        samples_checked = 0;
        do_reset();
        t_idcode();
        t_bypass();
        t_boundary();
        t_tms_reset();
        do_reset();
        t_idcode();
        report_and_stop();
    end
endmodule
`default_nettype wire
